// *** rtl/esf_consts.svh ***
// constants of the serial memory front end: opcodes, status layout, timing, host map
// assumes inclusion by bare name from any file that needs it
`ifndef ESF_CONSTS_SVH
`define ESF_CONSTS_SVH
// opcodes with bit 3 cleared; bit 3 is masked before compare
`define ESF_OP_MASK        8'hf7
`define ESF_OP_SET_WL      8'h06
`define ESF_OP_CLR_WL      8'h04
`define ESF_OP_RD_STAT     8'h05
`define ESF_OP_WR_STAT     8'h01
`define ESF_OP_RD_ARR      8'h03
`define ESF_OP_WR_ARR      8'h02
// status byte field positions and values
`define ESF_SR_BUSY        0
`define ESF_SR_WEL         1
`define ESF_SR_PLO         2
`define ESF_SR_PHI         3
`define ESF_SR_GPE         7
`define ESF_SR_RST         8'h00
`define ESF_SR_BUSY_VAL    8'hff
// self-timed write cycle
`define ESF_TWC_MS         5
`define ESF_PCLK_MHZ       125
`define ESF_TWC_CYC        (`ESF_TWC_MS * 1000 * `ESF_PCLK_MHZ)
// host register offsets
`define ESF_REG_CMD        12'h000
`define ESF_REG_TXD        12'h004
`define ESF_REG_RXD        12'h008
`define ESF_REG_STAT       12'h00c
`define ESF_REG_PINS       12'h010
// host command fields and link timing
`define ESF_CMD_TX         8
`define ESF_CMD_RX         9
`define ESF_PIN_WP         0
`define ESF_PIN_HOLD       1
`define ESF_SCK_HALF       3'h4
`endif

// *** rtl/esf_pkg.sv ***
// types shared by both ends of the serial memory link
// assumes the constants header is available for the numeric values
package esf_pkg;
  // device sequence after select
  typedef enum logic [2:0] {
    esf_st_opc   = 3'b000,
    esf_st_rdst  = 3'b001,
    esf_st_wdat  = 3'b010,
    esf_st_arr   = 3'b011,
    esf_st_done  = 3'b100,
    esf_st_dead  = 3'b101
  } esf_dev_st_t;
  // host link sequencer
  typedef enum logic [1:0] {
    esf_hs_idle  = 2'b00,
    esf_hs_lead  = 2'b01,
    esf_hs_shift = 2'b10,
    esf_hs_trail = 2'b11
  } esf_host_st_t;
endpackage : esf_pkg

// *** rtl/esf_link_if.sv ***
// serial link between host controller and memory front end
// assumes an external pull-up on the serial output line
`timescale 1ns/1ns
interface esf_link_if;
  logic sck;
  logic cs_n;
  logic si;
  logic hold_n;
  logic wp_n;
  logic so_o;
  logic so_oe_n;
  logic so_line;
  // resolved output line; pull-up wins while the device floats it
  assign so_line = so_oe_n ? 1'b1 : so_o;
  modport dev (
    input  sck,
    input  cs_n,
    input  si,
    input  hold_n,
    input  wp_n,
    output so_o,
    output so_oe_n
  );
  modport host (
    output sck,
    output cs_n,
    output si,
    output hold_n,
    output wp_n,
    input  so_line
  );
endinterface : esf_link_if

// *** rtl/esf_sync.sv ***
// two-flop level synchroniser, one per bit
// assumes each bit is a quasi-static level or a toggle
`timescale 1ns/1ns
module esf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : esf_sync

// *** rtl/esf_dev.sv ***
// memory front end: serial slave decoder and status register with write guard
// assumes the link clock idles low and is driven only by the host
`timescale 1ns/1ns
`include "esf_consts.svh"
// Overview of operation
// - device is slave; serial clock input only
// - bytes shift most significant bit first
// - first byte after select is opcode
// - bad opcode: ignore input, float output
// - deselected: ignore input, float output
// - pause low with clock low freezes
// - resume with clock low; paused clocks ignored
// - output floats outside status read, even while input is taken
// - guard pin high permits writes
// - guard low and enable set blocks status writes
// - guard fall while selected aborts status write
// - started write cycle ignores guard fall
// - guard enable zero ignores guard pin
// - decode opcodes with bit 3 ignored
// - status layout; all ones while busy
// - protection needs pin low and enable
// - write latch clear at reset
module esf_dev #(
  parameter int TWC_CYC = `ESF_TWC_CYC
) (
  esf_link_if.dev    link,
  input  wire logic  pclk,
  input  wire logic  presetn,
  output logic [7:0] status,
  output logic       wr_cycle
);
  // link domain
  esf_pkg::esf_dev_st_t state;
  logic [2:0] bit_cnt;
  logic [6:0] shreg;
  logic [7:0] byte_in;
  logic       link_rst;
  logic       byte_end;
  logic       tog_set;
  logic       tog_clr;
  logic       tog_wr;
  logic [7:0] wr_data;
  logic [7:0] stat_l;
  // core domain
  logic [2:0] tog_s;
  logic [2:0] tog_q;
  logic [1:0] pin_s;
  logic       cs_q;
  logic       wel;
  logic [1:0] plevel;
  logic       gpe;
  logic       pend;
  logic [7:0] pend_data;
  logic [31:0] twc_cnt;
  logic       guard;
  logic       ev_set;
  logic       ev_clr;
  logic       ev_wr;
  logic       cs_rise;

  // opcode compare with the don't-care bit removed
  function automatic logic op_is(input logic [7:0] b, input logic [7:0] op);
    op_is = ((b & `ESF_OP_MASK) == op);
  endfunction : op_is

  // deselect or reset clears the whole receive sequence
  assign link_rst = link.cs_n | ~presetn;
  assign byte_in  = {shreg, link.si};
  // a byte completes on its eighth unpaused rising edge
  assign byte_end = link.hold_n && (bit_cnt == 3'h7);

  // receiver: shift and sequence on rising link clock
  always_ff @(posedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      state   <= esf_pkg::esf_st_opc;
      bit_cnt <= 3'h0;
      shreg   <= 7'h00;
    end else if (link.hold_n && state != esf_pkg::esf_st_dead) begin
      shreg   <= byte_in[6:0];
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end) begin
        case (state)
          esf_pkg::esf_st_opc: begin
            if (op_is(byte_in, `ESF_OP_RD_STAT))
              state <= esf_pkg::esf_st_rdst;
            else if (op_is(byte_in, `ESF_OP_WR_STAT))
              state <= esf_pkg::esf_st_wdat;
            else if (op_is(byte_in, `ESF_OP_RD_ARR) || op_is(byte_in, `ESF_OP_WR_ARR))
              state <= esf_pkg::esf_st_arr;
            else if (op_is(byte_in, `ESF_OP_SET_WL) || op_is(byte_in, `ESF_OP_CLR_WL))
              state <= esf_pkg::esf_st_done;
            else
              state <= esf_pkg::esf_st_dead;
          end
          esf_pkg::esf_st_wdat: state <= esf_pkg::esf_st_done;
          default:              state <= state;
        endcase
      end
    end
  end

  // command events as toggles; they survive deselect so the core sees them
  always_ff @(posedge link.sck or negedge presetn) begin
    if (!presetn) begin
      tog_set <= 1'b0;
      tog_clr <= 1'b0;
      tog_wr  <= 1'b0;
      wr_data <= 8'h00;
    end else if (byte_end && !link.cs_n) begin
      if (state == esf_pkg::esf_st_opc && op_is(byte_in, `ESF_OP_SET_WL))
        tog_set <= ~tog_set;
      if (state == esf_pkg::esf_st_opc && op_is(byte_in, `ESF_OP_CLR_WL))
        tog_clr <= ~tog_clr;
      if (state == esf_pkg::esf_st_wdat) begin
        wr_data <= byte_in;
        tog_wr  <= ~tog_wr;
      end
    end
  end

  // status image brought into the link domain
  esf_sync #(
    .W (8)
  ) u_stat_sync (
    .clk   (link.sck),
    .rst_n (presetn),
    .d     (status),
    .q     (stat_l)
  );

  // transmitter: drive on falling edge, float unless reading status
  always_ff @(negedge link.sck or posedge link_rst) begin
    if (link_rst) begin
      link.so_oe_n <= 1'b1;
      link.so_o    <= 1'b0;
    end else if (!link.hold_n) begin
      link.so_oe_n <= 1'b1;
    end else begin
      link.so_oe_n <= (state != esf_pkg::esf_st_rdst);
      link.so_o    <= stat_l[3'h7 - bit_cnt];
    end
  end

  // core side: bring events and pins across
  esf_sync #(
    .W (3)
  ) u_tog_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({tog_wr, tog_clr, tog_set}),
    .q     (tog_s)
  );
  // pins enter inverted: flop reset value equals idle pins, so no false edge after reset
  esf_sync #(
    .W (2)
  ) u_pin_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({~link.wp_n, ~link.cs_n}),
    .q     (pin_s)
  );

  // edge detection on synchronised signals; pin_s[0] is select active
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tog_q <= 3'h0;
      cs_q  <= 1'b0;
    end else begin
      tog_q <= tog_s;
      cs_q  <= pin_s[0];
    end
  end
  assign ev_set  = tog_s[0] ^ tog_q[0];
  assign ev_clr  = tog_s[1] ^ tog_q[1];
  assign ev_wr   = tog_s[2] ^ tog_q[2];
  assign cs_rise = ~pin_s[0] & cs_q;
  // hardware protection only with pin low and enable set
  assign guard   = pin_s[1] & gpe;

  // write-enable latch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wel <= 1'b0;
    else if (wr_cycle)
      wel <= (twc_cnt == 32'd0) ? 1'b0 : wel;
    else if (ev_set)
      wel <= 1'b1;
    else if (ev_clr)
      wel <= 1'b0;
  end

  // pending status write, committed at deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend      <= 1'b0;
      pend_data <= 8'h00;
    end else if (ev_wr) begin
      pend      <= wel && !wr_cycle && !guard;
      pend_data <= wr_data;
    end else if (pend && pin_s[0] && guard) begin
      pend      <= 1'b0;
    end else if (pend && cs_rise) begin
      pend      <= 1'b0;
    end
  end

  // self-timed write cycle; once started the guard pin is not looked at
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_cycle <= 1'b0;
      twc_cnt  <= 32'd0;
      plevel   <= 2'b00;
      gpe      <= 1'b0;
    end else if (wr_cycle) begin
      if (twc_cnt == 32'd0)
        wr_cycle <= 1'b0;
      else
        twc_cnt <= twc_cnt - 32'd1;
    end else if (pend && cs_rise && !guard) begin
      wr_cycle <= 1'b1;
      twc_cnt  <= 32'(TWC_CYC - 1);
      plevel   <= {pend_data[`ESF_SR_PHI], pend_data[`ESF_SR_PLO]};
      gpe      <= pend_data[`ESF_SR_GPE];
    end
  end

  // status byte image
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      status <= `ESF_SR_RST;
    else if (wr_cycle)
      status <= `ESF_SR_BUSY_VAL;
    else
      status <= {gpe, 3'b000, plevel, wel, 1'b0};
  end
endmodule : esf_dev

// *** rtl/esf_host.sv ***
// host controller: APB register slave driving the serial memory link
// assumes the device floats its output when not answering
`timescale 1ns/1ns
`include "esf_consts.svh"
module esf_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  esf_link_if.host         link
);
  esf_pkg::esf_host_st_t st;
  logic [15:0] tx;
  logic [7:0]  txd;
  logic [7:0]  rxd;
  logic [4:0]  nbits;
  logic [4:0]  cnt;
  logic [2:0]  ph;
  logic        pause;
  logic        so_s;
  logic        tick;
  logic        wr_acc;
  logic        mapped;

  assign wr_acc = psel & penable & pready & pwrite;
  assign mapped = (paddr == `ESF_REG_CMD) || (paddr == `ESF_REG_TXD) ||
                  (paddr == `ESF_REG_RXD) || (paddr == `ESF_REG_STAT) ||
                  (paddr == `ESF_REG_PINS);
  assign tick   = (ph == `ESF_SCK_HALF - 3'h1);

  // serial output line into pclk domain
  esf_sync #(
    .W (1)
  ) u_so_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (link.so_line),
    .q     (so_s)
  );

  // bus answer: ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      case (paddr)
        `ESF_REG_TXD:  prdata <= {24'h000000, txd};
        `ESF_REG_RXD:  prdata <= {24'h000000, rxd};
        `ESF_REG_STAT: prdata <= {31'h0, st != esf_pkg::esf_hs_idle};
        `ESF_REG_PINS: prdata <= {30'h0, ~pause, link.wp_n}; // reads back as written
        default:       prdata <= 32'h0000_0000;
      endcase
    end
  end

  // pin control and transmit byte registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd       <= 8'h00;
      pause     <= 1'b0;
      link.wp_n <= 1'b1;
    end else if (wr_acc && paddr == `ESF_REG_TXD) begin
      txd <= pwdata[7:0];
    end else if (wr_acc && paddr == `ESF_REG_PINS) begin
      link.wp_n <= pwdata[`ESF_PIN_WP];
      pause     <= ~pwdata[`ESF_PIN_HOLD];
    end
  end

  // link sequencer: clock divider, select, shift msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= esf_pkg::esf_hs_idle;
      link.sck    <= 1'b0;
      link.cs_n   <= 1'b1;
      link.si     <= 1'b0;
      link.hold_n <= 1'b1;
      tx          <= 16'h0000;
      rxd         <= 8'h00;
      nbits       <= 5'd0;
      cnt         <= 5'd0;
      ph          <= 3'h0;
    end else begin
      ph <= tick ? 3'h0 : ph + 3'h1;
      // pause pin moves only while the clock is low
      if (tick && !link.sck)
        link.hold_n <= ~pause;
      case (st)
        esf_pkg::esf_hs_idle: begin
          if (wr_acc && paddr == `ESF_REG_CMD) begin
            tx        <= {pwdata[7:0], txd};
            nbits     <= (pwdata[`ESF_CMD_TX] | pwdata[`ESF_CMD_RX]) ? 5'd16 : 5'd8;
            cnt       <= 5'd0;
            link.cs_n <= 1'b0;
            link.si   <= pwdata[7];
            ph        <= 3'h0;
            st        <= esf_pkg::esf_hs_lead;
          end
        end
        esf_pkg::esf_hs_lead: begin
          if (tick)
            st <= esf_pkg::esf_hs_shift;
        end
        esf_pkg::esf_hs_shift: begin
          if (tick && !link.sck && !pause && link.hold_n) begin
            link.sck <= 1'b1;
            rxd      <= {rxd[6:0], so_s};
            cnt      <= cnt + 5'd1;
          end else if (tick && link.sck) begin
            link.sck <= 1'b0;
            tx       <= {tx[14:0], 1'b0};
            link.si  <= tx[14];
            if (cnt == nbits)
              st <= esf_pkg::esf_hs_trail;
          end
        end
        esf_pkg::esf_hs_trail: begin
          if (tick) begin
            link.cs_n <= 1'b1;
            st        <= esf_pkg::esf_hs_idle;
          end
        end
        default: st <= esf_pkg::esf_hs_idle;
      endcase
    end
  end
endmodule : esf_host

// *** verification/esf_assertions.sv ***
// concurrent checks on the serial link between host controller and memory front end
// assumes instantiation beside the link interface, sampled on the host clock
`timescale 1ns/1ns
module esf_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic so_o,
  input wire logic so_oe_n,
  input wire logic so_line
);
  logic       sck_q;
  logic [3:0] n_rise;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // counts rising link clock edges since select, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q  <= 1'b0;
      n_rise <= 4'h0;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        n_rise <= 4'h0;
      end else if (sck && !sck_q && n_rise != 4'hf) begin
        n_rise <= n_rise + 4'h1;
      end
    end
  end
  // one link clock high phase, then low
  sequence s_high_phase;
    sck [*4] ##1 !sck;
  endsequence
  // clock held low after select
  sequence s_lead;
    !sck [*4];
  endsequence
  AST_DESEL_FLOAT: assert property (cs_n |-> so_oe_n)
    else $error("output driven while deselected");
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("link clock moved outside a frame");
  AST_SCK_HALF: assert property ($rose(sck) |-> s_high_phase)
    else $error("link clock high phase wrong");
  AST_CS_LEAD: assert property ($fell(cs_n) |-> s_lead)
    else $error("clock rose too soon after select");
  AST_HOLD_CLK_LOW: assert property (!cs_n && $changed(hold_n) |-> !sck)
    else $error("pause pin moved with clock high");
  AST_SO_STEADY: assert property (!so_oe_n && sck && $past(sck) |-> $stable(so_o))
    else $error("output changed with clock high");
  AST_SI_STEADY: assert property (!cs_n && sck && sck_q |-> $stable(si))
    else $error("input changed with clock high");
  AST_SO_AFTER_OPC: assert property (!so_oe_n |-> n_rise >= 4'h8)
    else $error("output driven before opcode complete");
  AST_FLOAT_HIGH: assert property (so_oe_n |-> so_line)
    else $error("floating line not pulled up");
  AST_DRIVE_UNPAUSED: assert property ($fell(so_oe_n) |-> hold_n && !cs_n)
    else $error("output enabled while paused or deselected");
endmodule : esf_assertions

// *** verification/testbench.sv ***
// self-checking bench: software orders over APB, host drives the front end over the link
// assumes design files and the constants header are compiled first
`timescale 1ns/1ns
`include "esf_consts.svh"
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  status;
  logic        wr_cycle;
  logic        drove;
  logic [31:0] q;
  logic        e;
  int          n_mismatch;
  int          n_checks;
  esf_link_if lnk ();
  esf_host i_esf_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(lnk.host));
  esf_dev #(.TWC_CYC(20)) i_esf_dev (.link(lnk.dev), .pclk(pclk), .presetn(presetn),
    .status(status), .wr_cycle(wr_cycle));
  esf_assertions i_esf_assertions (.pclk(pclk), .presetn(presetn), .sck(lnk.sck),
    .cs_n(lnk.cs_n), .si(lnk.si), .hold_n(lnk.hold_n), .wp_n(lnk.wp_n), .so_o(lnk.so_o),
    .so_oe_n(lnk.so_oe_n), .so_line(lnk.so_line));
  // host clock
  always #4 pclk = ~pclk;
  // remembers whether the device ever drove its output
  always @(posedge pclk) if (lnk.so_oe_n === 1'b0) drove <= 1'b1;
  task automatic chk(input logic [31:0] s, input logic [31:0] x, input string m);
    n_checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, m, s, x);
    end
  endtask : chk
  // one APB transfer; read data and error land in q and e
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // polls the host until the link transfer is over
  task automatic idle();
    int i;
    q = 32'h1;
    for (i = 0; i < 300 && q[0] !== 1'b0; i++) apb(1'b0, `ESF_REG_STAT, 32'h0);
    chk({31'h0, q[0]}, 32'h0, "host stays busy");
  endtask : idle
  task automatic cmd(input logic [31:0] c, input logic [7:0] tx);
    apb(1'b1, `ESF_REG_TXD, {24'h0, tx});
    apb(1'b1, `ESF_REG_CMD, c);
    idle();
  endtask : cmd
  // waits out any write cycle, then compares the status image
  task automatic settle(input logic on, input logic [7:0] m, input logic [7:0] x);
    repeat (10) @(posedge pclk);
    chk({31'h0, wr_cycle}, {31'h0, on}, "write cycle");
    if (on) chk({24'h0, status}, 32'hff, "busy image");
    repeat (40) @(posedge pclk);
    chk({24'h0, status & m}, {24'h0, x}, "status");
  endtask : settle
  task automatic rd_rx(input logic [7:0] x);
    apb(1'b0, `ESF_REG_RXD, 32'h0);
    chk(q, {24'h0, x}, "received byte");
  endtask : rd_rx
  task automatic t_reset();
    chk({24'h0, status}, 32'h0, "reset status");
    chk({31'h0, lnk.so_oe_n}, 32'h1, "reset float");
    apb(1'b0, `ESF_REG_PINS, 32'h0);
    chk(q, 32'h3, "reset pins");
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
    $display("test reset done");
  endtask : t_reset
  task automatic t_latch();
    cmd(32'h00e, 8'h0);
    settle(1'b0, 8'hff, 8'h02);
    cmd(32'h004, 8'h0);
    settle(1'b0, 8'hff, 8'h00);
    cmd(32'h006, 8'h0);
    settle(1'b0, 8'hff, 8'h02);
    cmd(32'h205, 8'h0);
    rd_rx(8'h02);
    cmd(32'h101, 8'h8c);
    settle(1'b1, 8'hff, 8'h8c);
    cmd(32'h101, 8'h00);
    settle(1'b0, 8'hff, 8'h8c);
    $display("test latch and status write done");
  endtask : t_latch
  task automatic t_guard();
    cmd(32'h006, 8'h0);
    settle(1'b0, 8'hff, 8'h8e);
    apb(1'b1, `ESF_REG_TXD, 32'h0);
    apb(1'b1, `ESF_REG_CMD, 32'h101);
    // guard pin falls after the data byte ends but before deselect
    repeat (129) @(posedge pclk);
    apb(1'b1, `ESF_REG_PINS, 32'h2);
    idle();
    settle(1'b0, 8'hfd, 8'h8c);
    cmd(32'h101, 8'h00);
    settle(1'b0, 8'hfd, 8'h8c);
    $display("test guard done");
  endtask : t_guard
  task automatic t_unguard();
    int i;
    apb(1'b1, `ESF_REG_PINS, 32'h3);
    cmd(32'h006, 8'h0);
    cmd(32'h101, 8'h00);
    for (i = 0; i < 50 && wr_cycle !== 1'b1; i++) @(posedge pclk);
    apb(1'b1, `ESF_REG_PINS, 32'h2);
    settle(1'b1, 8'hff, 8'h00);
    cmd(32'h006, 8'h0);
    cmd(32'h101, 8'h0c);
    settle(1'b1, 8'hff, 8'h0c);
    $display("test guard disabled done");
  endtask : t_unguard
  task automatic t_bad_op();
    drove = 1'b0;
    cmd(32'h2ff, 8'h0);
    chk({31'h0, drove}, 32'h0, "driven after bad opcode");
    rd_rx(8'hff);
    cmd(32'h205, 8'h0);
    rd_rx(8'h0c);
    $display("test bad opcode done");
  endtask : t_bad_op
  task automatic t_pause();
    apb(1'b1, `ESF_REG_CMD, 32'h205);
    repeat (40) @(posedge pclk);
    apb(1'b1, `ESF_REG_PINS, 32'h0);
    repeat (80) @(posedge pclk);
    apb(1'b1, `ESF_REG_PINS, 32'h2);
    idle();
    rd_rx(8'h0c);
    $display("test pause done");
  endtask : t_pause
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    pclk       = 1'b0;
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h0;
    pwdata     = 32'h0;
    drove      = 1'b0;
    n_mismatch = 0;
    n_checks   = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_latch();
    t_guard();
    t_unguard();
    t_bad_op();
    t_pause();
    end_sim();
  end
  // watchdog
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
endmodule : testbench
